// File: hdl/ccdg_top.sv
/*
 digital view of the crystal oscillator: full-rate clock, divide-by-two clock, gating.
 assumes clk oversamples the crystal signal; enable and stop come from
 on-chip logic on clk; the amplifier input and bypass pin are asynchronous.
*/
// What this block does
// RULE1: crystal rate clock follows the crystal input at full rate, undivided.
// RULE2: half rate clock is the crystal clock divided by two, sent onward.
// RULE3: integration unit divides again, making the bus clock a quarter rate.
// RULE4: outputs run only while the integration unit's enable is asserted.
// RULE5: wait mode changes nothing; the crystal clock keeps running.
// RULE6: stop mode gates the crystal clock output off.
// RULE7: break state does not interrupt the crystal clock.
// RULE8: an external clock drives the amplifier input; amplifier output is unused but still driven as the gated inverted input.
// RULE9: logic uses only rising edges, never duty cycle; tolerates unstable start.
// RULE10: integration unit times stop recovery with 4096 or 32 crystal cycles.
// RULE11: in stop mode both the crystal and half rate clocks stop.
// RULE12: bypass pin low at monitor entry makes half rate equal crystal rate.
// RULE13: divider restarts in known phase; gating never makes short pulses; the amplifier output can still get one at gate open and close.
`include "ccdg_consts.svh"

module ccdg_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic amp_input_pin,
    output logic amp_output_pin,
    input wire logic oscillator_enable_from_integration,
    input wire logic stop_mode,
    input wire logic monitor_entry,
    input wire logic divider_bypass_pin,
    output logic crystal_rate_clock,
    output logic half_rate_clock
);
    import ccdg_pkg::*;

    logic xin;
    logic bypass_pin_s;
    logic run_ok;
    logic xin_rise;

    ccdg_gate_t state_reg;
    ccdg_gate_t state_next;
    logic xin_d_reg;
    logic xin_d_next;
    logic div_reg;
    logic div_next;
    logic bypass_reg;
    logic bypass_next;
    logic xclk_reg;
    logic xclk_next;
    logic half_reg;
    logic half_next;
    logic amp_reg;
    logic amp_next;

    // one decode of the gate state serves the output paths and the checks
    function automatic logic gate_is_on(ccdg_gate_t s);
        return s == CCDG_GATE_ON;
    endfunction

    ccdg_sync xin_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(amp_input_pin),
        .sync_out(xin)
    );

    ccdg_sync bypass_sync (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .async_in(divider_bypass_pin),
        .sync_out(bypass_pin_s)
    );

    // wait and break have no input here: only enable and stop may halt the clocks
    assign run_ok = oscillator_enable_from_integration & ~stop_mode; // RULE4 RULE5 RULE7
    // edge based, so the crystal duty cycle never matters
    assign xin_rise = xin & ~xin_d_reg; // RULE9

    always_comb begin
        state_next = state_reg;
        xin_d_next = xin;
        div_next = div_reg;
        bypass_next = bypass_reg;
        // bypass is latched once per monitor entry; changing it while running may glitch
        if (monitor_entry) begin
            bypass_next = ~bypass_pin_s; // RULE12
        end
        unique case (state_reg)
            CCDG_GATE_OFF: begin
                div_next = `CCDG_DIV_RESET; // RULE13
                // start only with the crystal low so the first pulse is whole
                if (run_ok && !xin) begin
                    state_next = CCDG_GATE_ON; // RULE4 RULE13
                end
            end
            CCDG_GATE_ON: begin
                if (xin_rise) begin
                    div_next = ~div_reg; // RULE2
                end
                // stop only with both clocks low; costs up to two crystal periods
                if (!run_ok && !xin && !div_reg) begin
                    state_next = CCDG_GATE_OFF; // RULE6 RULE11 RULE13
                end
            end
        endcase
        xclk_next = gate_is_on(state_reg) & xin; // RULE1 RULE6
        if (bypass_reg) begin
            half_next = gate_is_on(state_reg) & xin; // RULE12
        end else begin
            half_next = gate_is_on(state_reg) & div_reg; // RULE2 RULE11
        end
        // inverting amplifier image; unused when an external clock drives the input
        amp_next = gate_is_on(state_reg) & ~xin; // RULE8
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= CCDG_GATE_OFF;
            xin_d_reg <= 1'b0;
            div_reg <= `CCDG_DIV_RESET;
            bypass_reg <= `CCDG_BYPASS_RESET;
            xclk_reg <= `CCDG_CLK_OUT_RESET;
            half_reg <= `CCDG_CLK_OUT_RESET;
            amp_reg <= `CCDG_AMP_OUT_RESET;
        end else if (clk_en) begin
            state_reg <= state_next;
            xin_d_reg <= xin_d_next;
            div_reg <= div_next;
            bypass_reg <= bypass_next;
            xclk_reg <= xclk_next;
            half_reg <= half_next;
            amp_reg <= amp_next;
        end
    end

    assign crystal_rate_clock = xclk_reg;
    assign half_rate_clock = half_reg;
    assign amp_output_pin = amp_reg;

    // checks
    logic on;
    assign on = gate_is_on(state_reg);

    sequence running_s;
        clk_en && on && run_ok;
    endsequence

    sequence quiet_low_s;
        clk_en && on && !run_ok && !xin && !div_reg;
    endsequence

    sequence start_s;
        clk_en && !on && run_ok && !xin;
    endsequence

    crystal_follow_a: assert property (@(posedge clk) disable iff (reset) // RULE1
        clk_en && on |=> crystal_rate_clock == $past(xin))
        else $error("crystal rate clock does not follow the crystal input");

    half_toggle_a: assert property (@(posedge clk) disable iff (reset) // RULE2
        clk_en && on && !bypass_reg && xin_rise ##1 clk_en && !bypass_reg
        |=> half_rate_clock != $past(half_rate_clock))
        else $error("half rate clock missed a toggle");

    half_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE9
        clk_en && on && !bypass_reg && !xin_rise ##1 clk_en && on && !bypass_reg
        |=> $stable(half_rate_clock))
        else $error("half rate clock changed without a crystal rising edge");

    enable_gate_a: assert property (@(posedge clk) disable iff (reset) // RULE4
        (!on && clk_en)[*2] |=> !crystal_rate_clock && !half_rate_clock)
        else $error("clock output while the gate is off");

    stop_off_a: assert property (@(posedge clk) disable iff (reset) // RULE6
        quiet_low_s |=> !on ##1 !crystal_rate_clock)
        else $error("stop did not gate the clocks");

    keep_running_a: assert property (@(posedge clk) disable iff (reset) // RULE5
        running_s |=> on)
        else $error("clocks stopped while enabled and not in stop");

    restart_phase_a: assert property (@(posedge clk) disable iff (reset) // RULE13
        start_s |=> on && !div_reg && !crystal_rate_clock)
        else $error("restart not in the known phase");

    bypass_equal_a: assert property (@(posedge clk) disable iff (reset) // RULE12
        clk_en && on && bypass_reg |=> half_rate_clock == crystal_rate_clock)
        else $error("bypass does not pass the crystal rate");

    both_stop_a: assert property (@(posedge clk) disable iff (reset) // RULE11
        !on ##1 clk_en && !on |=> !half_rate_clock)
        else $error("half rate clock running in stop");

    amp_image_a: assert property (@(posedge clk) disable iff (reset) // RULE8
        clk_en && on |=> amp_output_pin == !$past(xin))
        else $error("amplifier output is not the inverted crystal image");

    amp_quiet_a: assert property (@(posedge clk) disable iff (reset) // RULE6
        clk_en && !on |=> !amp_output_pin)
        else $error("amplifier output active while the gate is off");

    div_cleared_a: assert property (@(posedge clk) disable iff (reset) // RULE13
        clk_en && !on |=> !div_reg)
        else $error("divider not cleared while the gate is off");

    bypass_latch_a: assert property (@(posedge clk) disable iff (reset) // RULE12
        clk_en && monitor_entry |=> bypass_reg == !$past(bypass_pin_s))
        else $error("bypass choice not taken at monitor entry");

    bypass_hold_a: assert property (@(posedge clk) disable iff (reset) // RULE12
        clk_en && !monitor_entry |=> $stable(bypass_reg))
        else $error("bypass choice changed outside monitor entry");

    gate_wait_a: assert property (@(posedge clk) disable iff (reset) // RULE13
        clk_en && !on && run_ok && xin |=> !on)
        else $error("gate opened with the crystal high");

    stop_wait_a: assert property (@(posedge clk) disable iff (reset) // RULE13
        clk_en && on && !run_ok && (xin || div_reg) |=> on)
        else $error("gate closed while a clock was high");
endmodule

// File: hdl/ccdg_consts.svh
/*
 constants for the crystal clock divider and gate.
 assumes inclusion by the package, the main module and the bench side.
*/
`ifndef CCDG_CONSTS_SVH
`define CCDG_CONSTS_SVH

`define CCDG_SYNC_STAGES 2
`define CCDG_DIV_RESET 1'b0
`define CCDG_CLK_OUT_RESET 1'b0
`define CCDG_BYPASS_RESET 1'b0
`define CCDG_AMP_OUT_RESET 1'b0
`define CCDG_STOP_REC_LONG 4096
`define CCDG_STOP_REC_SHORT 32

`endif

// File: hdl/ccdg_pkg.sv
/*
 types for the crystal clock divider and gate.
 assumes nothing beyond the constants header.
*/
`include "ccdg_consts.svh"

package ccdg_pkg;
    typedef enum logic [0:0] {
        CCDG_GATE_OFF = 1'b0,
        CCDG_GATE_ON = 1'b1
    } ccdg_gate_t;
endpackage

// File: hdl/ccdg_sync.sv
/*
 two flip-flop synchroniser for one level.
 assumes a single clock; the first stage feeds only the second.
*/
module ccdg_sync (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule

// File: sim/ccdg_siu_model.sv
/*
 model of the integration unit: divides the half rate clock again, drives enable and stop.
 assumes the block's clk and reset; requests come from the bench; stop recovery
 is timed in crystal clock cycles and reported on recovered.
*/
`include "ccdg_consts.svh"

module ccdg_siu_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic half_rate_clock,
    input wire logic crystal_rate_clock,
    input wire logic short_stop_recovery,
    input wire logic run_req,
    input wire logic stop_req,
    output logic oscillator_enable_from_integration,
    output logic stop_mode,
    output logic bus_clock,
    output logic recovered
);
    timeunit 1ns;
    timeprecision 1ps;
    logic half_d_reg;
    logic xclk_d_reg;
    int rec_cnt;
    int rec_len;
    // recovery length in crystal cycles, picked by the short-recovery bit
    assign rec_len = short_stop_recovery ? `CCDG_STOP_REC_SHORT : `CCDG_STOP_REC_LONG;
    always_ff @(posedge clk) begin
        if (reset) begin
            half_d_reg <= 1'b0;
            bus_clock <= 1'b0;
            xclk_d_reg <= 1'b0;
            rec_cnt <= 0;
            recovered <= 1'b1;
        end else begin
            half_d_reg <= half_rate_clock;
            xclk_d_reg <= crystal_rate_clock;
            if (half_rate_clock && !half_d_reg) bus_clock <= ~bus_clock;
            // counting starts once stop is released and crystal edges come back
            if (stop_req) begin
                rec_cnt <= 0;
                recovered <= 1'b0;
            end else if (!recovered && crystal_rate_clock && !xclk_d_reg) begin
                rec_cnt <= rec_cnt + 1;
                if (rec_cnt == rec_len - 1) recovered <= 1'b1;
            end
        end
    end
    assign oscillator_enable_from_integration = run_req;
    assign stop_mode = stop_req;
endmodule

// File: sim/testbench.sv
/*
 self-checking bench: crystal stimulus, edge counts of the gated clocks.
 assumes a crystal period of 8 clk cycles, well above the design's minimum.
*/
`include "ccdg_consts.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, xtal, run_req, stop_req, mon, byp, en, stp, bus;
    logic amp_out, xclk, hclk, ssr, rec;
    int err_count, n_tests, cyc, ph;
    ccdg_top u_ccdg_top (.clk(clk), .reset(reset), .clk_en(1'b1), .amp_input_pin(xtal),
        .amp_output_pin(amp_out), .oscillator_enable_from_integration(en), .stop_mode(stp),
        .monitor_entry(mon), .divider_bypass_pin(byp), .crystal_rate_clock(xclk),
        .half_rate_clock(hclk));
    ccdg_siu_model u_ccdg_siu_model (.clk(clk), .reset(reset), .half_rate_clock(hclk),
        .crystal_rate_clock(xclk), .short_stop_recovery(ssr), .run_req(run_req),
        .stop_req(stop_req), .oscillator_enable_from_integration(en),
        .stop_mode(stp), .bus_clock(bus), .recovered(rec));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // free-running crystal, changed off the sampling edge
    always @(negedge clk) begin
        ph <= (ph + 1) % 8;
        xtal <= (ph < 4);
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            give_verdict();
        end
    end
    task automatic chk(input int got, input int lo, input int hi);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("ERROR t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask
    // counts rising edges over n cycles, after letting the block settle
    task automatic count(input int n, output int nx, output int nh, output int nb);
        logic px, pq, pb;
        repeat (40) @(posedge clk);
        nx = 0;
        nh = 0;
        nb = 0;
        px = xclk;
        pq = hclk;
        pb = bus;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (xclk === 1'b1 && px === 1'b0) nx++;
            if (hclk === 1'b1 && pq === 1'b0) nh++;
            if (bus === 1'b1 && pb === 1'b0) nb++;
            px = xclk;
            pq = hclk;
            pb = bus;
        end
    endtask
    task automatic t_run();
        int nx, nh, nb;
        @(negedge clk) run_req = 1'b1;
        count(160, nx, nh, nb);
        chk(nx, 19, 21);
        chk(nh, 9, 11);
        chk(nb, 4, 6);
    endtask
    task automatic t_stop();
        int nx, nh, nb, n;
        @(negedge clk) stop_req = 1'b1;
        count(80, nx, nh, nb);
        chk(nx + nh, 0, 0);
        chk(int'(amp_out === 1'b0 && xclk === 1'b0), 1, 1);
        @(negedge clk) begin
            ssr = 1'b1;
            stop_req = 1'b0;
        end
        // short recovery: crystal periods of 8 clk cycles, plus the gate start
        n = 0;
        while (rec !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(n, `CCDG_STOP_REC_SHORT * 8 - 16, `CCDG_STOP_REC_SHORT * 8 + 24);
        count(80, nx, nh, nb);
        chk(nh, 4, 6);
        // long recovery must still be running well past the short count
        @(negedge clk) begin
            ssr = 1'b0;
            stop_req = 1'b1;
        end
        repeat (40) @(negedge clk);
        stop_req = 1'b0;
        repeat (300) @(posedge clk);
        #1;
        chk(int'(rec === 1'b0), 1, 1);
    endtask
    task automatic t_enable();
        int nx, nh, nb;
        @(negedge clk) run_req = 1'b0;
        count(80, nx, nh, nb);
        chk(nx + nh, 0, 0);
        @(negedge clk) run_req = 1'b1;
    endtask
    task automatic t_bypass();
        int nx, nh, nb;
        // pin high at monitor entry keeps the divider; the pin needs two cycles to sync
        @(negedge clk) byp = 1'b1;
        repeat (3) @(negedge clk);
        mon = 1'b1;
        @(negedge clk) mon = 1'b0;
        count(160, nx, nh, nb);
        chk(nh, 9, 11);
        @(negedge clk) byp = 1'b0;
        repeat (3) @(negedge clk);
        mon = 1'b1;
        @(negedge clk) mon = 1'b0;
        count(160, nx, nh, nb);
        chk(nh, 19, 21);
        chk(nb, 9, 11);
    endtask
    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        {reset, run_req, stop_req, mon, byp, xtal} = 6'h20;
        ssr = 1'b0;
        {err_count, n_tests, cyc, ph} = 0;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        t_run();
        t_stop();
        t_enable();
        t_bypass();
        give_verdict();
    end
endmodule
